/* File: rtl/ficu_pkg.sv */
package ficu_pkg;

  // Source count, polling order index 0 is the first polled source.
  localparam int NUM_SRC = 14;
  localparam int NUM_LVL = 4;

  // Source indices in polling order.
  localparam int SRC_EXT0  = 0;
  localparam int SRC_TMR0  = 1;
  localparam int SRC_EXT1  = 2;
  localparam int SRC_TMR1  = 3;
  localparam int SRC_SER   = 4;
  localparam int SRC_TMR2  = 5;
  localparam int SRC_EXT2  = 6;
  localparam int SRC_EXT3  = 7;
  localparam int SRC_SPI   = 8;
  localparam int SRC_ADC   = 9;
  localparam int SRC_PCA   = 10;
  localparam int SRC_BOD   = 11;
  localparam int SRC_UART2 = 12;
  localparam int SRC_KEYP  = 13;

  // Vector table layout.
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // APB register offsets (byte addresses).
  localparam logic [7:0] OFS_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_PRIO_LO  = 8'h04;
  localparam logic [7:0] OFS_PRIO_HI  = 8'h08;
  localparam logic [7:0] OFS_EXT_CTL  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;

  // Field positions.
  localparam int ENA_GLOBAL_BIT = 16;
  localparam int EXT_TYPE_LSB   = 0;
  localparam int EXT_FLAG_LSB   = 4;
  localparam int STS_INSRV_LSB  = 0;
  localparam int STS_PEND_LSB   = 8;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Core handshake carried as one bundle.
  typedef struct packed {
    logic last_cycle;   // Final cycle of the current instruction.
    logic is_return_from_interrupt;      // Instruction in progress is a return from irq.
    logic irq_reg_wr;   // Instruction in progress writes irq registers.
    logic ack;          // Core accepts the vector and starts the call.
    logic return_from_interrupt_done;    // Return from irq completed this cycle.
  } ficu_core_s;

  typedef struct packed {
    logic        call_req;
    logic [3:0]  src;
    logic [15:0] vector;
  } ficu_vec_s;

endpackage

/* File: rtl/ficu_ctrl.sv */
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
module ficu_ctrl
  import ficu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Core side.
  input  wire ficu_core_s        core_in,
  input  wire logic [NUM_SRC-1:0] periph_flags,
  input  wire logic [3:0]        ext_request_pin_n,
  output ficu_vec_s              vec_out
);

  // Core handshake, same clock domain, so no synchroniser.
  logic last_cycle;
  logic ack;
  logic return_from_interrupt_done;
  logic irq_instr;
  assign last_cycle = core_in.last_cycle;
  assign ack        = core_in.ack;
  assign return_from_interrupt_done  = core_in.return_from_interrupt_done;
  assign irq_instr  = core_in.is_return_from_interrupt | core_in.irq_reg_wr;

  // Software registers.
  logic [NUM_SRC-1:0] enable_q;
  logic               global_irq_enable_q;
  logic [NUM_SRC-1:0] prio_lo_q;
  logic [NUM_SRC-1:0] prio_hi_q;
  logic [3:0]         ext_type_q;
  logic [3:0]         ext_flag_q;
  logic [NUM_LVL-1:0] in_service_q;
  logic [NUM_SRC-1:0] sample_q;
  logic               hold_off_q;
  ficu_vec_s          vec_q;

  // Pin synchroniser: first stage feeds only the second.
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [3:0] pin_prev_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_q <= 4'hF;
      pin_sync_q <= 4'hF;
    end
    else
    begin
      pin_meta_q <= ext_request_pin_n;
      pin_sync_q <= pin_meta_q;
    end
  end

  // APB decode; every access completes with no wait state.
  logic apb_wr;
  logic apb_rd;
  logic hit_ena;
  logic hit_plo;
  logic hit_phi;
  logic hit_ext;
  logic hit_sts;
  logic hit_any;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & ~penable & ~pwrite;
  assign hit_ena = (paddr == OFS_ENABLE);
  assign hit_plo = (paddr == OFS_PRIO_LO);
  assign hit_phi = (paddr == OFS_PRIO_HI);
  assign hit_ext = (paddr == OFS_EXT_CTL);
  assign hit_sts = (paddr == OFS_STATUS);
  assign hit_any = hit_ena | hit_plo | hit_phi | hit_ext | hit_sts;

  // Edge and level detection on the sampled pins.
  logic [3:0] fall_edge;
  logic [3:0] low_level;
  assign fall_edge = pin_prev_q & ~pin_sync_q;
  assign low_level = ~pin_sync_q;

  // Current request vector: externals from flags, others from peripherals.
  logic [NUM_SRC-1:0] raw_req;
  always_comb
  begin
    raw_req            = periph_flags;
    raw_req[SRC_EXT0]  = ext_flag_q[0];
    raw_req[SRC_EXT1]  = ext_flag_q[1];
    raw_req[SRC_EXT2]  = ext_flag_q[2];
    raw_req[SRC_EXT3]  = ext_flag_q[3];
  end

  // Gated request seen by the poll.
  logic [NUM_SRC-1:0] gated;
  assign gated = sample_q & enable_q
               & {NUM_SRC{global_irq_enable_q}};

  // Per source level from its own two bits only.
  logic [1:0] src_lvl [NUM_SRC];
  generate
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_lvl
      assign src_lvl[g] = {prio_hi_q[g], prio_lo_q[g]};
    end
  endgenerate

  // Winner: highest level first, then earliest in polling order.
  logic             win_valid;
  logic [3:0]       win_src;
  logic [1:0]       win_lvl;
  always_comb
  begin
    win_valid = 1'b0;
    win_src   = 4'h0;
    win_lvl   = 2'h0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (gated[i] && (!win_valid || src_lvl[i] > win_lvl))
      begin
        win_valid = 1'b1;
        win_src   = 4'(i);
        win_lvl   = src_lvl[i];
      end
    end
  end

  // Highest level currently in service, and whether any is.
  logic       busy;
  logic [1:0] top_lvl;
  always_comb
  begin
    busy    = 1'b0;
    top_lvl = 2'h0;
    for (int l = 0; l < NUM_LVL; l++)
    begin
      if (in_service_q[l])
      begin
        busy    = 1'b1;
        top_lvl = 2'(l);
      end
    end
  end

  // A call may be raised only when every blocking condition is clear.
  logic lvl_ok;
  logic can_call;
  assign lvl_ok   = !busy || (win_lvl > top_lvl);
  assign can_call = win_valid && lvl_ok && last_cycle
                  && !irq_instr && !hold_off_q;

  // Vector address: base plus eight per polling position.
  logic [15:0] win_vec;
  assign win_vec = VEC_BASE + {win_src, 3'b000};

  // Acknowledged source and level from the held request.
  logic [1:0] ack_lvl;
  assign ack_lvl = src_lvl[vec_q.src];

  // Sample flags once per instruction cycle; poll uses only this sample.
  // Sampling only at instruction ends keeps the poll one instruction behind
  // the flags, so a flag shorter than one instruction may be missed.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sample_q <= '0;
    else if (last_cycle)
      sample_q <= raw_req;
  end

  // External flags: edge sets and holds, level follows the pin.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_prev_q <= 4'hF;
      ext_flag_q <= 4'h0;
    end
    else if (last_cycle)
    begin
      pin_prev_q <= pin_sync_q;
      for (int e = 0; e < 4; e++)
      begin
        if (!ext_type_q[e])
          ext_flag_q[e] <= low_level[e];
        else if (fall_edge[e])
          ext_flag_q[e] <= 1'b1;
        else if (ack && vec_q.call_req
                 && vec_q.src == ext_src(e))
          ext_flag_q[e] <= 1'b0;
        else if (apb_wr && hit_ext)
          ext_flag_q[e] <= pwdata[EXT_FLAG_LSB+e];
      end
    end
    else
    begin
      for (int e = 0; e < 4; e++)
      begin
        if (ext_type_q[e] && ack && vec_q.call_req
            && vec_q.src == ext_src(e))
          ext_flag_q[e] <= 1'b0;
        else if (ext_type_q[e] && apb_wr && hit_ext)
          ext_flag_q[e] <= pwdata[EXT_FLAG_LSB+e];
      end
    end
  end

  // Polling index of each external source.
  function automatic logic [3:0] ext_src(input int e);
    logic [3:0] r;
    r = 4'(SRC_EXT0);
    case (e)
      1:       r = 4'(SRC_EXT1);
      2:       r = 4'(SRC_EXT2);
      3:       r = 4'(SRC_EXT3);
      default: r = 4'(SRC_EXT0);
    endcase
    return r;
  endfunction

  // Vector request to the core; held until acknowledged.
  // Source and vector stay frozen while the request is up, so a better
  // request that arrives late waits for the first poll after the ack.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      vec_q <= '0;
    else if (vec_q.call_req)
    begin
      if (ack)
        vec_q.call_req <= 1'b0;
    end
    else if (can_call)
    begin
      vec_q.call_req <= 1'b1;
      vec_q.src      <= win_src;
      vec_q.vector   <= win_vec;
    end
  end

  // Next in-service state. A return and an acknowledge in the same cycle
  // both take effect, so that neither event is lost.
  logic [NUM_LVL-1:0] in_service_d;
  always_comb
  begin
    in_service_d = in_service_q;
    if (return_from_interrupt_done && busy)
      in_service_d[top_lvl] = 1'b0;
    if (ack && vec_q.call_req)
      in_service_d[ack_lvl] = 1'b1;
  end

  // In-service bits move only through the next-state logic above.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      in_service_q <= '0;
    else
      in_service_q <= in_service_d;
  end

  // Hold-off lasts until the next instruction completes.
  // Only instruction ends move it, so a stall cannot shorten the hold-off.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hold_off_q <= 1'b0;
    else if (last_cycle)
      hold_off_q <= irq_instr;
  end

  // Software register writes; flags handled with the pin logic.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_q            <= '0;
      global_irq_enable_q <= 1'b0;
      prio_lo_q           <= '0;
      prio_hi_q           <= '0;
      ext_type_q          <= 4'h0;
    end
    else if (apb_wr)
    begin
      if (hit_ena)
      begin
        enable_q            <= pwdata[NUM_SRC-1:0];
        global_irq_enable_q <= pwdata[ENA_GLOBAL_BIT];
      end
      if (hit_plo)
        prio_lo_q <= pwdata[NUM_SRC-1:0];
      if (hit_phi)
        prio_hi_q <= pwdata[NUM_SRC-1:0];
      if (hit_ext)
        ext_type_q <= pwdata[EXT_TYPE_LSB+:4];
    end
  end

  // Read mux, captured in setup so prdata is registered in access.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = RST_ZERO;
    if (hit_ena)
    begin
      rd_mux[NUM_SRC-1:0]    = enable_q;
      rd_mux[ENA_GLOBAL_BIT] = global_irq_enable_q;
    end
    if (hit_plo)
      rd_mux[NUM_SRC-1:0] = prio_lo_q;
    if (hit_phi)
      rd_mux[NUM_SRC-1:0] = prio_hi_q;
    if (hit_ext)
    begin
      rd_mux[EXT_TYPE_LSB+:4] = ext_type_q;
      rd_mux[EXT_FLAG_LSB+:4] = ext_flag_q;
    end
    if (hit_sts)
    begin
      rd_mux[STS_INSRV_LSB+:NUM_LVL] = in_service_q;
      rd_mux[STS_PEND_LSB+:NUM_SRC]  = gated;
    end
  end

  // APB answer: zero wait states, error for unmapped addresses.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      prdata  <= RST_ZERO;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      if (apb_rd)
        prdata <= rd_mux;
    end
  end

  assign vec_out = vec_q;

endmodule

/* File: verif/ficu_checker.sv */
`timescale 1ns/1ns
// Port relations of the controller; one clock, so defaults apply.
module ficu_checker
  import ficu_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire ficu_core_s core_in,
  input wire ficu_vec_s  vec_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Decoded map, so that a refusal is tied to its address.
  wire logic map_ok = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};

  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_apb_single: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_map_error: assert property (pready |-> pslverr == !map_ok)
    else $error("refusal flag wrong for address");
  a_vec_pair: assert property (vec_out.call_req |->
    vec_out.vector == VEC_BASE + VEC_STEP * {12'h000, vec_out.src})
    else $error("vector does not match source");
  a_req_hold: assert property (vec_out.call_req && !core_in.ack |=>
    vec_out.call_req && $stable(vec_out.vector))
    else $error("call dropped before ack");
  a_ack_drop: assert property (vec_out.call_req && core_in.ack |=>
    !vec_out.call_req)
    else $error("call still up after ack");
  a_poll_gate: assert property ($rose(vec_out.call_req) |->
    $past(core_in.last_cycle) && !$past(core_in.is_return_from_interrupt)
    && !$past(core_in.irq_reg_wr))
    else $error("call from a blocked poll");
  a_return_from_interrupt_holdoff: assert property ($rose(vec_out.call_req) |->
    !$past(core_in.is_return_from_interrupt, 2) && !$past(core_in.irq_reg_wr, 2))
    else $error("call right after a return or irq write");
endmodule

bind ficu_ctrl ficu_checker i_ficu_checker (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .core_in(core_in), .vec_out(vec_out));

/* File: verif/ficu_core_model.sv */
`timescale 1ns/1ns
// Core stand-in: one-cycle instructions unless stalled, ack a few cycles after a call.
module ficu_core_model
  import ficu_pkg::*;
#(
  parameter logic [1:0] ACK_WAIT = 2'h2
)
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ret_go,
  input  wire logic       wr_go,
  input  wire logic       stall,
  input  wire ficu_vec_s  vec_out,
  output ficu_core_s      core_in
);
  logic [1:0] cnt_q;
  logic       ack_q;

  // A stall stretches the current instruction; a return or a write to the
  // irq registers is an instruction that ends in its own cycle.
  assign core_in = '{last_cycle: !stall, is_return_from_interrupt: ret_go, irq_reg_wr: wr_go,
                     ack: ack_q, return_from_interrupt_done: ret_go};

  // A late ack shows that the call is held while the core is busy.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 2'h0;
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= vec_out.call_req && !ack_q && cnt_q == ACK_WAIT;
      cnt_q <= (vec_out.call_req && !ack_q) ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: verif/four_level_interrupt_controller_tb.sv */
`timescale 1ns/1ns
module four_level_interrupt_controller_tb
  import ficu_pkg::*;
;
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic               ret_go = 1'b0;
  logic               wr_go = 1'b0;
  logic               stall = 1'b0;
  logic [NUM_SRC-1:0] flags = '0;
  logic [3:0]         pins_n = 4'hF;
  logic               pready;
  logic               pslverr;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               er;
  ficu_core_s         core_in;
  ficu_vec_s          vec_out;
  int                 err_total = 0;
  int                 total_checks = 0;
  int                 cycles = 0;

  ficu_ctrl i_ficu_ctrl (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .core_in(core_in), .periph_flags(flags),
    .ext_request_pin_n(pins_n), .vec_out(vec_out));
  ficu_core_model i_ficu_core_model (.clk(clk), .resetn(resetn),
    .ret_go(ret_go), .wr_go(wr_go), .stall(stall), .vec_out(vec_out),
    .core_in(core_in));

  // Clock, and a ceiling on the run so that a hang still ends in a report.
  initial forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    wr_go <= w; // The core reports the irq register write as it lands.
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    wr_go <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic ret_pulse();
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      chk(vec_out.call_req, 1'b0);
    end
  endtask

  // Waits for a call, checks its source and vector, then for the ack.
  task automatic take(input int s);
    while (vec_out.call_req !== 1'b1)
      @(posedge clk);
    chk(vec_out.src, s);
    chk(vec_out.vector, VEC_BASE + VEC_STEP * s);
    while (vec_out.call_req === 1'b1)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  task automatic serve(input int s);
    take(s);
    flags[s] <= 1'b0;
    repeat (3) @(posedge clk);
    ret_pulse();
  endtask

  // Main sequence; every wait is cut short by the cycle ceiling.
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rdc(OFS_ENABLE, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    wr(8'h14, 32'hFFFF_FFFF);
    chk(er, 1'b1);
    rdc(8'h14, 32'h0);
    $display("registers done");
    flags[SRC_TMR0] <= 1'b1;
    wr(OFS_ENABLE, 32'h0000_0002);
    idle(20);
    stall <= 1'b1; // A long instruction must hold off the call.
    wr(OFS_ENABLE, 32'h0001_0002);
    idle(8);
    stall <= 1'b0;
    take(SRC_TMR0);
    idle(20);
    rdc(OFS_STATUS, 32'h0000_0201);
    ret_pulse();
    serve(SRC_TMR0);
    $display("gating done");
    wr(OFS_PRIO_LO, 32'h0000_000A);
    wr(OFS_PRIO_HI, 32'h0000_0012);
    wr(OFS_ENABLE, 32'h0001_001A);
    flags[SRC_TMR1] <= 1'b1;
    flags[SRC_SER] <= 1'b1;
    take(SRC_SER);
    flags[SRC_SER] <= 1'b0;
    flags[SRC_TMR0] <= 1'b1;
    take(SRC_TMR0);
    flags[SRC_TMR0] <= 1'b0;
    rdc(OFS_STATUS, 32'h0000_080C);
    ret_pulse();
    idle(10);
    ret_pulse();
    serve(SRC_TMR1);
    wr(OFS_ENABLE, 32'h0001_0220);
    flags[SRC_ADC] <= 1'b1;
    flags[SRC_TMR2] <= 1'b1;
    serve(SRC_TMR2);
    serve(SRC_ADC);
    $display("priority done");
    wr(OFS_EXT_CTL, 32'h0000_0001);
    wr(OFS_ENABLE, 32'h0001_0001);
    pins_n[0] <= 1'b0;
    take(SRC_EXT0);
    rdc(OFS_EXT_CTL, 32'h0000_0001);
    ret_pulse();
    idle(20);
    wr(OFS_EXT_CTL, 32'h0);
    take(SRC_EXT0);
    rdc(OFS_EXT_CTL, 32'h0000_0010);
    pins_n[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(OFS_EXT_CTL, 32'h0);
    ret_pulse();
    idle(20);
    wr(OFS_ENABLE, 32'h0000_0001);
    pins_n[0] <= 1'b0;
    repeat (8) @(posedge clk);
    pins_n[0] <= 1'b1;
    repeat (8) @(posedge clk);
    wr(OFS_ENABLE, 32'h0001_0001);
    idle(20);
    $display("external done");
    finish_test();
  end
endmodule
